// ==== hw/rmc_nvm_defaults.sv ====
module rmc_nvm_defaults
	import rmc_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// nonvolatile page image
	input  wire logic       nvm_valid,
	input  wire logic [7:0] nvm_hys,
	input  wire logic [7:0] nvm_state_src,
	input  wire logic [7:0] nvm_warn_th,
	input  wire logic [7:0] nvm_ot_th,
	// chosen defaults and load strobe
	output logic      [7:0] def_hys,
	output logic      [7:0] def_state_src,
	output logic      [7:0] def_warn_th,
	output logic      [7:0] def_ot_th,
	output logic            load_pulse
);
	typedef struct packed {
		logic       done;
		logic       pulse;
		logic [7:0] hys;
		logic [7:0] src;
		logic [7:0] warn;
		logic [7:0] ot;
	} rmc_nvm_state_t;

	rmc_nvm_state_t st;
	rmc_nvm_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.pulse = 1'b0;
		if (!st.done) begin
			next_st.done = 1'b1;
			next_st.pulse = 1'b1;
			if (nvm_valid) begin
				next_st.hys  = nvm_hys;
				next_st.src  = nvm_state_src & MASK_STATE_SRC;
				next_st.warn = nvm_warn_th;
				next_st.ot   = nvm_ot_th;
			end
		end
	end

	// image is caught after reset release, never by the reset itself
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st <= '{done: 1'b0, pulse: 1'b0, hys: RST_OC_WARN_HYS, src: RST_STATE_SRC,
				warn: RST_WARN_TH, ot: RST_OT_TH};
		end else begin
			st <= next_st;
		end
	end

	assign def_hys       = st.hys;
	assign def_state_src = st.src;
	assign def_warn_th   = st.warn;
	assign def_ot_th     = st.ot;
	assign load_pulse    = st.pulse;
endmodule

// ==== hw/rmc_pkg.sv ====
package rmc_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_FIXED_MAX_HIGH = 8'ha3;
	localparam logic [7:0] ADDR_OC_WARN_HYS    = 8'ha4;
	localparam logic [7:0] ADDR_STATE_SRC      = 8'ha5;
	localparam logic [7:0] ADDR_WARN_TH        = 8'ha6;
	localparam logic [7:0] ADDR_OT_TH          = 8'ha7;
	localparam logic [7:0] ADDR_PWR_HIGH       = 8'ha9;
	localparam logic [7:0] ADDR_PWR_LOW        = 8'haa;
	localparam logic [7:0] ADDR_FIXED_MAX_LOW  = 8'ha2;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_FIXED_MAX_HIGH  = 8'h01;
	localparam logic [7:0] RST_FIXED_MAX_LOW   = 8'hff;
	localparam logic [7:0] RST_OC_WARN_HYS     = 8'h00;
	localparam logic [7:0] RST_STATE_SRC       = 8'h00;
	localparam logic [7:0] RST_WARN_TH         = 8'h8c;
	localparam logic [7:0] RST_OT_TH           = 8'ha5;
	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int BIT_IGNORE_LOWEST = 3;
	localparam int BIT_FORCE_LOWEST  = 2;
	localparam int BIT_WARN_SRC      = 1;
	localparam int BIT_OT_SRC        = 0;
	localparam logic [7:0] MASK_STATE_SRC = 8'h0f;
	localparam logic [7:0] MASK_FIXED_HIGH = 8'h01;
	// ----------------------------------------
	// scaling
	// ----------------------------------------
	localparam logic [8:0] FIXED_OFF_CODE     = 9'h000;
	localparam int         FIXED_BASE_MV      = 245;
	localparam int         FIXED_STEP_MV      = 5;
	localparam logic [7:0] TEMP_OFFSET_C      = 8'h28;
	localparam logic [7:0] THRESH_DISABLED    = 8'h00;
	localparam int         HYS_DIVISOR        = 384;
	localparam int         PWR_FULL_CODE      = 1023;
	// power states; lowest is the light-load state
	localparam logic [2:0] STATE_HIGHEST = 3'h0;
	localparam logic [2:0] STATE_LOWEST  = 3'h7;
endpackage

// ==== hw/rmc_rail_regs.sv ====
module rmc_rail_regs
	import rmc_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// register port from the serial host decoder
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_hit,
	// nonvolatile defaults
	input  wire logic       nvm_valid,
	input  wire logic [7:0] nvm_hys,
	input  wire logic [7:0] nvm_state_src,
	input  wire logic [7:0] nvm_warn_th,
	input  wire logic [7:0] nvm_ot_th,
	// power state interface
	input  wire logic       force_highest_state,
	input  wire logic       state_cmd_valid,
	input  wire logic [2:0] state_cmd,
	output logic      [2:0] reported_state,
	output logic      [2:0] operating_state,
	output logic            state_cmd_ack,
	output logic            phase_mgmt_forced,
	// thermal thresholds
	input  wire logic [7:0] link_warn_th,
	input  wire logic [7:0] link_ot_th,
	output logic      [7:0] warn_threshold_c,
	output logic            warn_enable,
	output logic      [7:0] ot_threshold_c,
	output logic            ot_enable,
	// fixed max voltage and hysteresis
	output logic      [8:0] max_fixed_voltage_code,
	output logic      [11:0] max_fixed_target_mv,
	output logic      [7:0] overcurrent_warning_hysteresis,
	// power report
	input  wire logic [9:0] system_power_report
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] fix_low;
		logic       fix_high;
		logic [7:0] hys;
		logic [3:0] src;
		logic [7:0] warn;
		logic [7:0] ot;
		logic [7:0] pwr_low_hold;
		logic [7:0] rdata;
		logic [2:0] rep;
		logic [2:0] op;
		logic       ack;
		logic [7:0] warn_c;
		logic       warn_en;
		logic [7:0] ot_c;
		logic       ot_en;
		logic [11:0] target_mv;
	} rmc_regs_state_t;

	rmc_regs_state_t st;
	rmc_regs_state_t next_st;

	logic [7:0] def_hys;
	logic [7:0] def_state_src;
	logic [7:0] def_warn_th;
	logic [7:0] def_ot_th;
	logic       load_pulse;
	logic       ignore_lowest_state;
	logic       force_lowest_state;
	logic [8:0] code;
	logic [7:0] warn_src_val;
	logic [7:0] ot_src_val;

	rmc_nvm_defaults u_defaults (
		.ref_clk       (ref_clk),
		.reset_n       (reset_n),
		.nvm_valid     (nvm_valid),
		.nvm_hys       (nvm_hys),
		.nvm_state_src (nvm_state_src),
		.nvm_warn_th   (nvm_warn_th),
		.nvm_ot_th     (nvm_ot_th),
		.def_hys       (def_hys),
		.def_state_src (def_state_src),
		.def_warn_th   (def_warn_th),
		.def_ot_th     (def_ot_th),
		.load_pulse    (load_pulse)
	);

	assign ignore_lowest_state = st.src[BIT_IGNORE_LOWEST];
	assign force_lowest_state  = st.src[BIT_FORCE_LOWEST];
	assign code = {st.fix_high, st.fix_low};

	assign warn_src_val = st.src[BIT_WARN_SRC] ? st.warn : link_warn_th;
	assign ot_src_val = st.src[BIT_OT_SRC] ? st.ot : link_ot_th;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;

		if (load_pulse) begin
			next_st.hys  = def_hys;
			next_st.src  = def_state_src[3:0];
			next_st.warn = def_warn_th;
			next_st.ot   = def_ot_th;
		end

		if (reg_wr) begin
			case (reg_addr)
				ADDR_FIXED_MAX_LOW:  next_st.fix_low = reg_wdata;
				ADDR_FIXED_MAX_HIGH: next_st.fix_high = reg_wdata[0];
				ADDR_OC_WARN_HYS:    next_st.hys = reg_wdata;
				ADDR_STATE_SRC:      next_st.src = reg_wdata[3:0];
				ADDR_WARN_TH:        next_st.warn = reg_wdata;
				ADDR_OT_TH:          next_st.ot = reg_wdata;
				default: begin
				end
			endcase
		end

		next_st.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_FIXED_MAX_LOW:  next_st.rdata = st.fix_low;
				ADDR_FIXED_MAX_HIGH: next_st.rdata = {7'h00, st.fix_high};
				ADDR_OC_WARN_HYS:    next_st.rdata = st.hys;
				ADDR_STATE_SRC:      next_st.rdata = {4'h0, st.src};
				ADDR_WARN_TH:        next_st.rdata = st.warn;
				ADDR_OT_TH:          next_st.rdata = st.ot;
				ADDR_PWR_HIGH: begin
					next_st.rdata = {6'h00, system_power_report[9:8]};
					next_st.pwr_low_hold = system_power_report[7:0];
				end
				ADDR_PWR_LOW:        next_st.rdata = st.pwr_low_hold;
				default:             next_st.rdata = 8'h00;
			endcase
		end

		if (state_cmd_valid) begin
			next_st.rep = state_cmd;
			next_st.ack = 1'b1;
		end

		if (force_highest_state) begin
			next_st.op = STATE_HIGHEST;
		end else if (force_lowest_state && !ignore_lowest_state) begin
			next_st.op = STATE_LOWEST;
		end else if (ignore_lowest_state && !force_lowest_state && next_st.rep == STATE_LOWEST) begin
			next_st.op = STATE_HIGHEST;
		end else begin
			next_st.op = next_st.rep;
		end

		next_st.warn_c = warn_src_val - TEMP_OFFSET_C;
		next_st.warn_en = (warn_src_val != THRESH_DISABLED);
		next_st.ot_c = ot_src_val - TEMP_OFFSET_C;
		next_st.ot_en = (ot_src_val != THRESH_DISABLED);

		if (code == FIXED_OFF_CODE) begin
			next_st.target_mv = 12'h000;
		end else begin
			next_st.target_mv = 12'(FIXED_BASE_MV) + 12'(code) * 12'(FIXED_STEP_MV);
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st <= '{fix_low: RST_FIXED_MAX_LOW, fix_high: RST_FIXED_MAX_HIGH[0], hys: RST_OC_WARN_HYS,
				src: RST_STATE_SRC[3:0], warn: RST_WARN_TH, ot: RST_OT_TH, pwr_low_hold: 8'h00,
				rdata: 8'h00, rep: STATE_HIGHEST, op: STATE_HIGHEST, ack: 1'b0, warn_c: 8'h00,
				warn_en: 1'b0, ot_c: 8'h00, ot_en: 1'b0, target_mv: 12'h000};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata = st.rdata;
	assign reg_hit = (reg_addr == ADDR_FIXED_MAX_LOW) || (reg_addr == ADDR_FIXED_MAX_HIGH) ||
		(reg_addr == ADDR_OC_WARN_HYS) || (reg_addr == ADDR_STATE_SRC) || (reg_addr == ADDR_WARN_TH) ||
		(reg_addr == ADDR_OT_TH) || (reg_addr == ADDR_PWR_HIGH) || (reg_addr == ADDR_PWR_LOW);
	assign reported_state = st.rep;
	assign operating_state = st.op;
	assign state_cmd_ack = st.ack;
	// phase management is held on whenever the lowest state is being forced
	assign phase_mgmt_forced = force_lowest_state && !ignore_lowest_state && !force_highest_state;
	assign warn_threshold_c = st.warn_c;
	assign warn_enable = st.warn_en;
	assign ot_threshold_c = st.ot_c;
	assign ot_enable = st.ot_en;
	assign max_fixed_voltage_code = code;
	assign max_fixed_target_mv = st.target_mv;
	assign overcurrent_warning_hysteresis = st.hys;
endmodule

// ==== testbench/rmc_host.sv ====
module rmc_host (
	// clock and read data
	input wire logic  ref_clk,
	input wire logic  [7:0] reg_rdata,
	// request
	output logic [7:0] reg_addr,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [7:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// released lines show the inverse so a stale value never passes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk) #10;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk) #10;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk) #10;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk) #10;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// ==== testbench/rmc_rail_regs_checker.sv ====
module rmc_rail_regs_checker
	import rmc_pkg::*;
(
	// clock, reset, register port
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	// state and derived outputs
	input wire logic        force_highest_state,
	input wire logic        state_cmd_valid,
	input wire logic [2:0]  state_cmd,
	input wire logic [2:0]  reported_state,
	input wire logic [2:0]  operating_state,
	input wire logic        state_cmd_ack,
	input wire logic        phase_mgmt_forced,
	input wire logic [8:0]  max_fixed_voltage_code,
	input wire logic [11:0] max_fixed_target_mv,
	input wire logic [7:0]  overcurrent_warning_hysteresis,
	input wire logic [9:0]  system_power_report
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// properties
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_code_high_bit: assert property (reg_wr && reg_addr == ADDR_FIXED_MAX_HIGH |=>
		max_fixed_voltage_code[8] == $past(reg_wdata[0])) else $error("code high bit lost");
	a_code_low_byte: assert property (reg_wr && reg_addr == ADDR_FIXED_MAX_LOW |=>
		max_fixed_voltage_code[7:0] == $past(reg_wdata)) else $error("code low byte lost");
	a_off_code_zero: assert property ($past(reset_n) && $past(max_fixed_voltage_code) == FIXED_OFF_CODE |->
		max_fixed_target_mv == 12'h000) else $error("off code not zero volts");
	a_target_step: assert property ($past(reset_n) && $past(max_fixed_voltage_code) != FIXED_OFF_CODE |->
		max_fixed_target_mv == 12'(FIXED_BASE_MV + FIXED_STEP_MV * $past(max_fixed_voltage_code)))
		else $error("target voltage wrong");
	a_hys_write: assert property (reg_wr && reg_addr == ADDR_OC_WARN_HYS |=>
		overcurrent_warning_hysteresis == $past(reg_wdata)) else $error("hysteresis not stored");
	a_cmd_ack: assert property (state_cmd_valid |=> state_cmd_ack && reported_state == $past(state_cmd))
		else $error("command not acknowledged");
	a_ack_cause: assert property (state_cmd_ack |-> $past(state_cmd_valid)) else $error("stray ack");
	a_force_high: assert property (force_highest_state |=> operating_state == STATE_HIGHEST)
		else $error("highest override lost");
	a_force_low: assert property (reg_wr && reg_addr == ADDR_STATE_SRC && reg_wdata[3:2] == 2'b01
		&& !force_highest_state |=> phase_mgmt_forced ##1 (operating_state == STATE_LOWEST || $past(force_highest_state)))
		else $error("lowest override lost");
	a_power_high: assert property (reg_rd && reg_addr == ADDR_PWR_HIGH |=>
		reg_rdata == {6'h00, $past(system_power_report[9:8])}) else $error("power high byte wrong");
	a_power_pair: assert property (reg_rd && reg_addr == ADDR_PWR_HIGH ##2 reg_rd && reg_addr == ADDR_PWR_LOW
		|=> reg_rdata == $past(system_power_report[7:0], 3)) else $error("power low byte not coherent");
	c_lowest_cmd: cover property (state_cmd_valid && state_cmd == STATE_LOWEST);
	c_mode_write: cover property (reg_wr && reg_addr == ADDR_STATE_SRC);
	c_low_read: cover property (reg_rd && reg_addr == ADDR_PWR_LOW);
endmodule

bind rmc_rail_regs rmc_rail_regs_checker i_chk (
	.ref_clk                        (ref_clk),
	.reset_n                        (reset_n),
	.reg_addr                       (reg_addr),
	.reg_wr                         (reg_wr),
	.reg_rd                         (reg_rd),
	.reg_wdata                      (reg_wdata),
	.reg_rdata                      (reg_rdata),
	.force_highest_state            (force_highest_state),
	.state_cmd_valid                (state_cmd_valid),
	.state_cmd                      (state_cmd),
	.reported_state                 (reported_state),
	.operating_state                (operating_state),
	.state_cmd_ack                  (state_cmd_ack),
	.phase_mgmt_forced              (phase_mgmt_forced),
	.max_fixed_voltage_code         (max_fixed_voltage_code),
	.max_fixed_target_mv            (max_fixed_target_mv),
	.overcurrent_warning_hysteresis (overcurrent_warning_hysteresis),
	.system_power_report            (system_power_report)
);

// ==== testbench/testbench.sv ====
module testbench;
	import rmc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] a, w, r, x;} rmc_row_t;
	logic ref_clk = 1'b0, reset_n = 1'b0, nvm_valid = 1'b0, force_highest_state = 1'b0, state_cmd_valid = 1'b0;
	logic [2:0] state_cmd = 3'h0, reported_state, operating_state, c;
	logic [7:0] link_warn_th = 8'h00, link_ot_th = 8'h00, reg_addr, reg_wdata, reg_rdata, d;
	logic [7:0] warn_threshold_c, ot_threshold_c, overcurrent_warning_hysteresis;
	logic       reg_wr, reg_rd, reg_hit, state_cmd_ack, phase_mgmt_forced, warn_enable, ot_enable;
	logic       hit_seen = 1'b0;
	logic [8:0] max_fixed_voltage_code;
	logic [11:0] max_fixed_target_mv;
	logic [9:0] system_power_report = 10'h000;
	logic [7:0] nv[4] = '{8'h21, 8'h03, 8'h5e, 8'h7a};
	wire logic [7:0] nvm_hys = nv[0], nvm_state_src = nv[1], nvm_warn_th = nv[2], nvm_ot_th = nv[3];
	int bad_count = 0, compares = 0, cycles = 0;
	rmc_row_t rows[7] = '{'{8'ha2, 8'h5a, 8'h5a, 8'hff}, '{8'ha3, 8'hff, 8'h01, 8'h01},
		'{8'ha4, 8'h3c, 8'h3c, 8'h00}, '{8'ha5, 8'hff, 8'h0f, 8'h00}, '{8'ha6, 8'h00, 8'h00, 8'h8c},
		'{8'ha7, 8'h55, 8'h55, 8'ha5}, '{8'ha8, 8'h12, 8'h00, 8'h00}};
	rmc_rail_regs i_dut (.*);
	rmc_host i_host (.*);
	always #50 ref_clk = ~ref_clk;
	// decode flag as it stood on the edge that took the read
	always @(posedge ref_clk) begin
		if (reg_rd) hit_seen <= reg_hit;
	end
	// ----
	// helpers
	// ----
	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic stop_test;
		$display("counts: %0d compares, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic do_reset;
		@(posedge ref_clk) #10 reset_n = 1'b0;
		repeat (3) @(posedge ref_clk);
		#10 reset_n = 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#10;
	endtask
	task automatic cmd(input logic [2:0] s);
		@(posedge ref_clk) #10;
		state_cmd = s;
		state_cmd_valid = 1'b1;
		@(posedge ref_clk) #10 state_cmd_valid = 1'b0;
	endtask
	function automatic logic [2:0] exp_state(input logic [3:0] m, input logic f, input logic [2:0] s);
		if (f) return STATE_HIGHEST;
		if (m[2] && !m[3]) return STATE_LOWEST;
		if (m[3] && !m[2] && s == STATE_LOWEST) return STATE_HIGHEST;
		return s;
	endfunction
	// ----
	// sequence
	// ----
	initial begin
		do_reset();
		foreach (rows[i]) begin
			i_host.rd(rows[i].a, d);
			chk(d, rows[i].x);
			chk(hit_seen, rows[i].a != 8'ha8);
		end
		foreach (rows[i]) begin
			i_host.wr(rows[i].a, rows[i].w);
			i_host.rd(rows[i].a, d);
			chk(d, rows[i].r);
		end
		$display("test registers done");
		chk(max_fixed_voltage_code, 12'h15a);
		chk(max_fixed_target_mv, 12'h7b7);
		chk(overcurrent_warning_hysteresis, 12'h03c);
		chk(warn_enable, 12'h000);
		chk(ot_threshold_c, 12'h02d);
		chk(ot_enable, 12'h001);
		i_host.wr(8'ha6, 8'h8c);
		i_host.wr(8'ha2, 8'h00);
		i_host.wr(8'ha3, 8'h00);
		settle();
		chk(warn_threshold_c, 12'h064);
		chk(max_fixed_target_mv, 12'h000);
		link_warn_th = 8'h50;
		i_host.wr(8'ha5, 8'h00);
		settle();
		chk(warn_threshold_c, 12'h028);
		chk(ot_enable, 12'h000);
		$display("test thresholds done");
		for (int m = 0; m < 16; m += 4) begin
			for (int f = 0; f < 2; f++) begin
				force_highest_state = f[0];
				i_host.wr(8'ha5, 8'(m));
				for (int j = 0; j < 2; j++) begin
					c = j ? 3'h3 : STATE_LOWEST;
					cmd(c);
					chk(state_cmd_ack, 12'h001);
					chk(reported_state, c);
					chk(operating_state, exp_state(4'(m), f[0], c));
					chk(phase_mgmt_forced, m == 4 && f == 0);
				end
			end
		end
		force_highest_state = 1'b0;
		$display("test power states done");
		system_power_report = 10'h2c7;
		i_host.rd(ADDR_PWR_HIGH, d);
		chk(d, 12'h002);
		system_power_report = 10'h100;
		i_host.rd(ADDR_PWR_LOW, d);
		chk(d, 12'h0c7);
		$display("test power report done");
		nvm_valid = 1'b1;
		do_reset();
		for (int i = 0; i < 4; i++) begin
			i_host.rd(8'ha4 + 8'(i), d);
			chk(d, nv[i]);
		end
		$display("test defaults done");
		stop_test();
	end
endmodule
